//--- mailbox_pkg.sv
// Constants and types shared by the ownership mailbox register bank and its requester
package mailbox_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] OFS_MSG_ONE     = 12'h34c;
  localparam logic [11:0] OFS_MSG_TWO     = 12'h350;
  localparam logic [11:0] OFS_MSG_THREE   = 12'h354;
  localparam logic [11:0] OFS_LOCK_LOW    = 12'h358;
  localparam logic [11:0] OFS_LOCK_HIGH   = 12'h35c;
  localparam logic [11:0] OFS_MASTER_CTL  = 12'h400;
  localparam int          MSG_WORDS       = 3;
  localparam int          LOCK_COUNT      = 8;
  localparam int          LOCK_FLAG_BIT   = 7;
  localparam int          RETRY_LIMIT_LSB = 28;
  localparam int          RELEASE_CNT_LSB = 24;
  localparam int          ARB_LEVEL_LSB   = 22;
  localparam int          ARB_STYLE_BIT   = 21;
  localparam int          ARB_RELEASE_BIT = 20;
  localparam int          HOLD_REQ_BIT    = 19;
  localparam int          HOLD_GRANT_BIT  = 18;
  localparam int          BURST_LSB       = 12;
  localparam int          BUS_NO_LSB      = 0;
  localparam int          CFG_BUS_LSB     = 16;
  localparam logic [3:0]  RETRY_LIMIT_RST = 4'h8;
  localparam logic [3:0]  RELEASE_CNT_RST = 4'h0;
  localparam logic [1:0]  ARB_LEVEL_RST   = 2'h3;
  localparam logic [3:0]  RELEASE_EVERY   = 4'hf;
  localparam logic [3:0]  RELEASE_MAX_SET = 4'h5;
  localparam logic [12:0] RELEASE_BASE    = 13'h0080;
  localparam int          RETRY_SHIFT     = 6;
  localparam logic [3:0]  LANE_CTL_HOLD   = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_POLL    = 2'b01,
    ST_ACCESS  = 2'b10,
    ST_RELEASE = 2'b11
  } req_state_type;
endpackage : mailbox_pkg

//--- reg_link_if.sv
// Register access link between the register bank and its requester
`timescale 1ns/1ps
interface reg_link_if;
  import mailbox_pkg::*;
  logic              req;
  logic              we;
  logic              from_vme;
  logic [ADDR_W-1:0] addr;
  logic [3:0]        be;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              ack;

  modport device_mp (input req, we, from_vme, addr, be, wdata, output rdata, ack);
  modport requester_mp (output req, we, from_vme, addr, be, wdata, input rdata, ack);
endinterface : reg_link_if

//--- vme_ownership_mailbox_regs.sv
// Mailbox, lock flag and master control register bank with bus hold logic
`timescale 1ns/1ps
// Summary of operation
// - Owner label writable only while its flag is 0
// - Lock flag registers take single-byte accesses only
// - Hold bit set keeps bus busy asserted
// - Hold bit leaves PCI target traffic untouched
// - No early release while bus is held
// - Poll granted bit low before setting hold
// - Bus error while held: requester clears hold
// - VME masters never set the hold bit
// - Early release when drained byte count reached
// - Code 1111 releases after every transaction
// - Release codes 0-5 mean 128 to 4096 bytes
// - Bus number match gives Type 0, else 1
// - Retry limit: 0 forever, else field times 64
// - Granted bit shows bus held through hold bit
module vme_ownership_mailbox_regs
  import mailbox_pkg::*;
#(
  parameter int RETRY_W = 10,
  parameter int BEAT_W  = 4
) (
  input  wire logic              CLK,
  input  wire logic              SRST,
  reg_link_if.device_mp          LINK,
  input  wire logic              BUS_GRANT,
  output logic                   BBSY_OUT,
  output logic                   EARLY_RELEASE,
  input  wire logic              PW_ACTIVE,
  input  wire logic              PW_BEAT,
  input  wire logic [BEAT_W-1:0] PW_BEAT_BYTES,
  input  wire logic              PW_TXN_END,
  input  wire logic [23:0]       CFG_VME_ADDR,
  output logic                   CFG_TYPE1,
  input  wire logic              RETRY_SEEN,
  input  wire logic              RETRY_DONE,
  output logic                   RETRY_ERR,
  output logic [3:0]             ARB_LEVEL,
  output logic                   ARB_STYLE,
  output logic                   ARB_RELEASE,
  output logic [1:0]             BURST_SIZE
);
  if (RETRY_W < 10 || BEAT_W < 1 || BEAT_W > 13) begin : g_bad_param
    $error("vme_ownership_mailbox_regs: unsupported parameter value");
  end

  logic [DATA_W-1:0] msg_ff [MSG_WORDS];
  logic [7:0]        lock_ff [LOCK_COUNT];
  logic [3:0]        retry_limit_ff;
  logic [3:0]        release_cnt_ff;
  logic [1:0]        arb_level_ff;
  logic              arb_style_ff;
  logic              arb_release_ff;
  logic              hold_req_ff;
  logic              hold_grant_ff;
  logic [1:0]        burst_ff;
  logic [7:0]        bus_no_ff;
  logic              ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              bbsy_ff;
  logic              early_ff;
  logic [12:0]       drained_ff;
  logic [RETRY_W-1:0] retry_cnt_ff;
  logic              retry_err_ff;
  logic              type1_ff;
  logic              take;
  logic              wr;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] ctl_word;
  logic [12:0]       release_bytes;
  logic [12:0]       nxt_drained;
  logic              count_hit;
  logic              early_now;
  logic [RETRY_W-1:0] retry_limit;

  assign take = LINK.req && !ack_ff;
  assign wr   = take && LINK.we;

  // Link answer one cycle after the request is taken
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= take;
      if (take) begin
        rdata_ff <= LINK.we ? rdata_ff : nxt_rdata;
      end
    end
  end
  assign LINK.ack   = ack_ff;
  assign LINK.rdata = rdata_ff;

  // Message words, byte lanes, either bus
  for (genvar w = 0; w < MSG_WORDS; w++) begin : g_msg
    for (genvar b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge CLK) begin
        if (SRST) begin
          msg_ff[w][8*b+:8] <= 8'h00;
        end else if (wr && LINK.be[b] &&
                     LINK.addr == OFS_MSG_ONE + 12'(4 * w)) begin
          msg_ff[w][8*b+:8] <= LINK.wdata[8*b+:8];
        end
      end
    end
  end

  // Lock flags, one flag and owner label per byte lane
  for (genvar s = 0; s < LOCK_COUNT; s++) begin : g_lock
    localparam logic [11:0] LOCK_OFS = (s < 4) ? OFS_LOCK_LOW : OFS_LOCK_HIGH;
    always_ff @(posedge CLK) begin
      if (SRST) begin
        lock_ff[s] <= 8'h00;
      end else if (wr && LINK.be[s%4] && LINK.addr == LOCK_OFS) begin
        lock_ff[s][LOCK_FLAG_BIT] <= LINK.wdata[8*(s%4)+LOCK_FLAG_BIT];
        if (!lock_ff[s][LOCK_FLAG_BIT]) begin
          lock_ff[s][6:0] <= LINK.wdata[8*(s%4)+:7];
        end
      end
    end
  end

  // Master control fields by byte lane
  always_ff @(posedge CLK) begin
    if (SRST) begin
      retry_limit_ff <= RETRY_LIMIT_RST;
      release_cnt_ff <= RELEASE_CNT_RST;
      arb_level_ff   <= ARB_LEVEL_RST;
      arb_style_ff   <= 1'b0;
      arb_release_ff <= 1'b0;
      hold_req_ff    <= 1'b0;
      burst_ff       <= 2'h0;
      bus_no_ff      <= 8'h00;
    end else if (wr && LINK.addr == OFS_MASTER_CTL) begin
      if (LINK.be[3]) begin
        retry_limit_ff <= LINK.wdata[RETRY_LIMIT_LSB+:4];
        release_cnt_ff <= LINK.wdata[RELEASE_CNT_LSB+:4];
      end
      if (LINK.be[2]) begin
        arb_level_ff   <= LINK.wdata[ARB_LEVEL_LSB+:2];
        arb_style_ff   <= LINK.wdata[ARB_STYLE_BIT];
        arb_release_ff <= LINK.wdata[ARB_RELEASE_BIT];
        hold_req_ff    <= LINK.wdata[HOLD_REQ_BIT];
      end
      if (LINK.be[1]) begin
        burst_ff <= LINK.wdata[BURST_LSB+:2];
      end
      if (LINK.be[0]) begin
        bus_no_ff <= LINK.wdata[BUS_NO_LSB+:8];
      end
    end
  end

  always_comb begin
    ctl_word = '0;
    ctl_word[RETRY_LIMIT_LSB+:4] = retry_limit_ff;
    ctl_word[RELEASE_CNT_LSB+:4] = release_cnt_ff;
    ctl_word[ARB_LEVEL_LSB+:2]   = arb_level_ff;
    ctl_word[ARB_STYLE_BIT]      = arb_style_ff;
    ctl_word[ARB_RELEASE_BIT]    = arb_release_ff;
    ctl_word[HOLD_REQ_BIT]       = hold_req_ff;
    ctl_word[HOLD_GRANT_BIT]     = hold_grant_ff;
    ctl_word[BURST_LSB+:2]       = burst_ff;
    ctl_word[BUS_NO_LSB+:8]      = bus_no_ff;
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    case (LINK.addr)
      OFS_MSG_ONE:    nxt_rdata = msg_ff[0];
      OFS_MSG_TWO:    nxt_rdata = msg_ff[1];
      OFS_MSG_THREE:  nxt_rdata = msg_ff[2];
      OFS_LOCK_LOW:   nxt_rdata = {lock_ff[3], lock_ff[2], lock_ff[1], lock_ff[0]};
      OFS_LOCK_HIGH:  nxt_rdata = {lock_ff[7], lock_ff[6], lock_ff[5], lock_ff[4]};
      OFS_MASTER_CTL: nxt_rdata = ctl_word;
      default:        nxt_rdata = '0;
    endcase
  end

  // Posted write release threshold
  assign release_bytes = RELEASE_BASE << release_cnt_ff[2:0];
  assign nxt_drained   = drained_ff + 13'(PW_BEAT_BYTES);
  assign count_hit     = PW_BEAT && (release_cnt_ff <= RELEASE_MAX_SET) &&
                         (nxt_drained >= release_bytes);
  assign early_now     = bbsy_ff && PW_ACTIVE && !hold_req_ff &&
                         (count_hit ||
                          (release_cnt_ff == RELEASE_EVERY && PW_TXN_END));

  // Bus busy ownership; the hold touches only this, not target traffic
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bbsy_ff <= 1'b0;
      early_ff <= 1'b0;
    end else begin
      early_ff <= early_now;
      if (!bbsy_ff) begin
        bbsy_ff <= BUS_GRANT && (hold_req_ff || PW_ACTIVE);
      end else if (hold_req_ff) begin
        bbsy_ff <= 1'b1;
      end else if (early_now) begin
        bbsy_ff <= 1'b0;
      end else if (!PW_ACTIVE || PW_TXN_END) begin
        bbsy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      hold_grant_ff <= 1'b0;
    end else begin
      hold_grant_ff <= hold_req_ff && bbsy_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      drained_ff <= 13'h0000;
    end else if (!bbsy_ff || early_now || PW_TXN_END) begin
      drained_ff <= 13'h0000;
    end else if (PW_BEAT) begin
      drained_ff <= nxt_drained;
    end
  end

  // Retry counting for the PCI master
  assign retry_limit = RETRY_W'(retry_limit_ff) << RETRY_SHIFT;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      retry_cnt_ff <= '0;
      retry_err_ff <= 1'b0;
    end else begin
      retry_err_ff <= 1'b0;
      if (RETRY_DONE) begin
        retry_cnt_ff <= '0;
      end else if (RETRY_SEEN && retry_limit_ff != 4'h0) begin
        if (retry_cnt_ff + 1'b1 >= retry_limit) begin
          retry_cnt_ff <= '0;
          retry_err_ff <= 1'b1;
        end else begin
          retry_cnt_ff <= retry_cnt_ff + 1'b1;
        end
      end
    end
  end

  // Configuration cycle type by bus number
  always_ff @(posedge CLK) begin
    if (SRST) begin
      type1_ff <= 1'b0;
    end else begin
      type1_ff <= CFG_VME_ADDR[CFG_BUS_LSB+:8] != bus_no_ff;
    end
  end

  assign BBSY_OUT      = bbsy_ff;
  assign EARLY_RELEASE = early_ff;
  assign CFG_TYPE1     = type1_ff;
  assign RETRY_ERR     = retry_err_ff;
  assign ARB_LEVEL     = {2'b00, arb_level_ff};
  assign ARB_STYLE     = arb_style_ff;
  assign ARB_RELEASE   = arb_release_ff;
  assign BURST_SIZE    = burst_ff;
endmodule : vme_ownership_mailbox_regs

//--- mailbox_requester.sv
// Requester end: issues register accesses for PCI or VME software
`timescale 1ns/1ps
module mailbox_requester
  import mailbox_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              SRST,
  reg_link_if.requester_mp       LINK,
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire logic              CMD_WRITE,
  input  wire logic              CMD_FROM_VME,
  input  wire logic [ADDR_W-1:0] CMD_ADDR,
  input  wire logic [3:0]        CMD_BE,
  input  wire logic [DATA_W-1:0] CMD_WDATA,
  output logic                   RSP_VALID,
  output logic                   RSP_REFUSED,
  output logic [DATA_W-1:0]      RSP_DATA,
  input  wire logic              BERR_IN,
  output logic                   HOLD_SET
);
  req_state_type     state_ff;
  logic              we_ff;
  logic              vme_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0]        be_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [7:0]        shadow_ff;
  logic              hold_set_ff;
  logic              rsp_valid_ff;
  logic              rsp_refused_ff;
  logic [DATA_W-1:0] rsp_data_ff;
  logic              is_lock;
  logic              one_lane;
  logic              sets_hold;
  logic              refuse;
  logic              berr_release;

  assign is_lock   = CMD_ADDR == OFS_LOCK_LOW || CMD_ADDR == OFS_LOCK_HIGH;
  assign one_lane  = $onehot(CMD_BE);
  assign sets_hold = CMD_WRITE && CMD_ADDR == OFS_MASTER_CTL && CMD_BE[2] &&
                     CMD_WDATA[HOLD_REQ_BIT];
  assign refuse    = (is_lock && !one_lane) ||
                     (sets_hold && CMD_FROM_VME);
  assign berr_release = BERR_IN && hold_set_ff;
  assign CMD_READY = state_ff == ST_IDLE && !berr_release;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff       <= ST_IDLE;
      we_ff          <= 1'b0;
      vme_ff         <= 1'b0;
      addr_ff        <= '0;
      be_ff          <= 4'h0;
      wdata_ff       <= '0;
      rsp_valid_ff   <= 1'b0;
      rsp_refused_ff <= 1'b0;
      rsp_data_ff    <= '0;
    end else begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (berr_release) begin
            state_ff <= ST_RELEASE;
          end else if (CMD_VALID) begin
            we_ff    <= CMD_WRITE;
            vme_ff   <= CMD_FROM_VME;
            addr_ff  <= CMD_ADDR;
            be_ff    <= CMD_BE;
            wdata_ff <= CMD_WDATA;
            if (refuse) begin
              rsp_valid_ff   <= 1'b1;
              rsp_refused_ff <= 1'b1;
              rsp_data_ff    <= '0;
            end else begin
              state_ff <= sets_hold ? ST_POLL : ST_ACCESS;
            end
          end
        end
        ST_POLL: begin
          if (LINK.ack && !LINK.rdata[HOLD_GRANT_BIT]) begin
            state_ff <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (LINK.ack) begin
            state_ff       <= ST_IDLE;
            rsp_valid_ff   <= 1'b1;
            rsp_refused_ff <= 1'b0;
            rsp_data_ff    <= we_ff ? '0 : LINK.rdata;
          end
        end
        ST_RELEASE: begin
          if (LINK.ack) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Last control byte written, and whether this side holds the bus
  always_ff @(posedge CLK) begin
    if (SRST) begin
      shadow_ff   <= {ARB_LEVEL_RST, 6'h00};
      hold_set_ff <= 1'b0;
    end else if (LINK.ack && LINK.we && LINK.addr == OFS_MASTER_CTL && LINK.be[2]) begin
      shadow_ff   <= LINK.wdata[23:16];
      hold_set_ff <= LINK.wdata[HOLD_REQ_BIT];
    end
  end

  always_comb begin
    LINK.req      = state_ff != ST_IDLE;
    LINK.we       = we_ff;
    LINK.from_vme = vme_ff;
    LINK.addr     = addr_ff;
    LINK.be       = be_ff;
    LINK.wdata    = wdata_ff;
    if (state_ff == ST_POLL) begin
      LINK.we   = 1'b0;
      LINK.addr = OFS_MASTER_CTL;
      LINK.be   = 4'hf;
    end else if (state_ff == ST_RELEASE) begin
      LINK.we       = 1'b1;
      LINK.from_vme = 1'b0;
      LINK.addr     = OFS_MASTER_CTL;
      LINK.be       = LANE_CTL_HOLD;
      LINK.wdata    = {8'h00, shadow_ff, 16'h0000};
      LINK.wdata[HOLD_REQ_BIT] = 1'b0;
    end
  end

  assign RSP_VALID   = rsp_valid_ff;
  assign RSP_REFUSED = rsp_refused_ff;
  assign RSP_DATA    = rsp_data_ff;
  assign HOLD_SET    = hold_set_ff;
endmodule : mailbox_requester

//--- mailbox_link_checker.sv
// Link and bus ownership assertions for the mailbox register bank
`timescale 1ns/1ps
module mailbox_link_checker
  import mailbox_pkg::*;
(
  input wire logic              CLK,
  input wire logic              SRST,
  input wire logic              req,
  input wire logic              we,
  input wire logic              from_vme,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0]        be,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              ack,
  input wire logic              BUS_GRANT,
  input wire logic              BBSY_OUT,
  input wire logic              EARLY_RELEASE,
  input wire logic [23:0]       CFG_VME_ADDR,
  input wire logic              CFG_TYPE1
);
  logic       hold_ff;
  logic [7:0] bus_no_ff;
  logic       ctl_wr;
  logic       vme_ctl;
  logic [7:0] cfg_bus;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  assign ctl_wr  = req && !ack && we && (addr == OFS_MASTER_CTL);
  assign cfg_bus = CFG_VME_ADDR[23:16];
  assign vme_ctl = req && we && from_vme && (addr == OFS_MASTER_CTL) && be[2];

  // Shadow of the hold bit
  always_ff @(posedge CLK) begin
    if (SRST)
      hold_ff <= 1'b0;
    else if (ctl_wr && be[2])
      hold_ff <= wdata[HOLD_REQ_BIT];
  end

  // Shadow of the bus number field
  always_ff @(posedge CLK) begin
    if (SRST)
      bus_no_ff <= 8'h00;
    else if (ctl_wr && be[0])
      bus_no_ff <= wdata[7:0];
  end

  AST_ACK_AFTER_TAKE: assert property (req && !ack |=> ack)
    else $error("ack missing one cycle after request taken");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(ack) |-> $past(req))
    else $error("ack without request");
  AST_HOLD_KEEPS_BBSY: assert property (hold_ff && BBSY_OUT |=> BBSY_OUT)
    else $error("bus busy dropped while hold bit set");
  AST_HOLD_ACQUIRES: assert property (hold_ff && BUS_GRANT |-> ##[0:2] BBSY_OUT)
    else $error("bus busy not taken with hold and grant");
  AST_NO_EARLY_HELD: assert property (hold_ff && $past(hold_ff) |-> !EARLY_RELEASE)
    else $error("early release while bus held");
  AST_EARLY_DROPS_BBSY: assert property (EARLY_RELEASE |-> !BBSY_OUT && $past(BBSY_OUT))
    else $error("early release without bus busy dropping");
  AST_CFG_TYPE: assert property (!$past(SRST) |->
    CFG_TYPE1 == ($past(cfg_bus) != $past(bus_no_ff)))
    else $error("configuration cycle type wrong");
  AST_NO_VME_HOLD: assert property (vme_ctl |-> !wdata[HOLD_REQ_BIT])
    else $error("hold bit set from the VME side");

  cover property (hold_ff && BBSY_OUT);
  cover property (EARLY_RELEASE);
  cover property (CFG_TYPE1);
  cover property (vme_ctl);
endmodule : mailbox_link_checker

//--- vme_ownership_mailbox_regs_tb.sv
// Self-checking bench for the mailbox register bank and its requester
`timescale 1ns/1ps
module vme_ownership_mailbox_regs_tb;
  import mailbox_pkg::*;
  logic        clk, srst, grant, pw_act, pw_beat, pw_end, rty_seen, rty_done, berr;
  logic        cmd_valid, cmd_ready, cmd_write, cmd_vme, rsp_valid, rsp_refused, hold_set;
  logic        bbsy, early, cfg_type1, rty_err, r, arb_sty, arb_rel;
  logic [11:0] cmd_addr, a;
  logic [3:0]  cmd_be, beat_bytes, b, arb_lvl;
  logic [1:0]  burst;
  logic [31:0] cmd_wdata, rsp_data, q;
  logic [23:0] cfg_addr;
  logic [11:0] msg[3]  = '{OFS_MSG_ONE, OFS_MSG_TWO, OFS_MSG_THREE};
  logic [7:0]  lw[5]   = '{8'h05, 8'h85, 8'h9f, 8'h00, 8'h22};
  logic [7:0]  lx[5]   = '{8'h05, 8'h85, 8'h85, 8'h05, 8'h22};
  int          error_cnt, check_count, cycles, e_cnt, r_cnt, base;

  reg_link_if link();

  vme_ownership_mailbox_regs vme_ownership_mailbox_regs_i (.CLK(clk), .SRST(srst),
    .LINK(link), .BUS_GRANT(grant), .BBSY_OUT(bbsy), .EARLY_RELEASE(early),
    .PW_ACTIVE(pw_act), .PW_BEAT(pw_beat), .PW_BEAT_BYTES(beat_bytes), .PW_TXN_END(pw_end),
    .CFG_VME_ADDR(cfg_addr), .CFG_TYPE1(cfg_type1), .RETRY_SEEN(rty_seen),
    .RETRY_DONE(rty_done), .RETRY_ERR(rty_err), .ARB_LEVEL(arb_lvl), .ARB_STYLE(arb_sty),
    .ARB_RELEASE(arb_rel), .BURST_SIZE(burst));

  mailbox_requester mailbox_requester_i (.CLK(clk), .SRST(srst), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
    .CMD_FROM_VME(cmd_vme), .CMD_ADDR(cmd_addr), .CMD_BE(cmd_be), .CMD_WDATA(cmd_wdata),
    .RSP_VALID(rsp_valid), .RSP_REFUSED(rsp_refused), .RSP_DATA(rsp_data),
    .BERR_IN(berr), .HOLD_SET(hold_set));

  mailbox_link_checker mailbox_link_checker_i (.CLK(clk), .SRST(srst), .req(link.req),
    .we(link.we), .from_vme(link.from_vme), .addr(link.addr), .be(link.be),
    .wdata(link.wdata), .ack(link.ack),
    .BUS_GRANT(grant), .BBSY_OUT(bbsy), .EARLY_RELEASE(early),
    .CFG_VME_ADDR(cfg_addr), .CFG_TYPE1(cfg_type1));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulse counters and hang guard
  always @(negedge clk) begin
    if (early === 1'b1)
      e_cnt++;
    if (rty_err === 1'b1)
      r_cnt++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input logic w, input logic v, input logic [11:0] ad, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_vme   = v;
    cmd_addr  = ad;
    cmd_be    = be;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1)
      @(negedge clk);
    q = rsp_data;
    r = rsp_refused;
  endtask : cmd

  task automatic wr(input logic v, input logic [11:0] ad, input logic [3:0] be,
                    input logic [31:0] d, input logic ref_exp);
    cmd(1'b1, v, ad, be, d);
    check({31'h0, r}, {31'h0, ref_exp});
  endtask : wr

  task automatic rd(input logic v, input logic [11:0] ad, input logic [31:0] exp);
    cmd(1'b0, v, ad, 4'hf, 32'h0);
    check(q, exp);
  endtask : rd

  task automatic pw_run(input logic [3:0] code, input int n);
    wr(1'b0, OFS_MASTER_CTL, 4'h8, {4'h8, code, 24'h0}, 1'b0);
    wr(1'b0, OFS_MASTER_CTL, 4'h4, 32'h00c80000, 1'b0);
    repeat (3) @(negedge clk);
    pw_act = 1'b1;
    wr(1'b0, OFS_MASTER_CTL, 4'h4, 32'h00c00000, 1'b0);
    base = e_cnt;
    pw_beat = 1'b1;
    repeat (n - 1) @(negedge clk);
    check(e_cnt - base, 0);
    check({31'h0, bbsy}, 32'h1);
    pw_beat = (code != RELEASE_EVERY);
    pw_end = (code == RELEASE_EVERY);
    @(negedge clk);
    check({31'h0, bbsy}, 32'h0);
    {pw_act, pw_beat, pw_end} = 3'b000;
    repeat (3) @(negedge clk);
    check(e_cnt - base, 1);
  endtask : pw_run

  task automatic retry_run(input logic [3:0] lim, input int n);
    wr(1'b0, OFS_MASTER_CTL, 4'h8, {lim, 4'h0, 24'h0}, 1'b0);
    rty_done = 1'b1;
    @(negedge clk);
    rty_done = 1'b0;
    base = r_cnt;
    rty_seen = 1'b1;
    repeat (n - 1) @(negedge clk);
    check(r_cnt - base, 0);
    @(negedge clk);
    rty_seen = 1'b0;
    repeat (3) @(negedge clk);
    check(r_cnt - base, (lim != 4'h0) ? 1 : 0);
  endtask : retry_run

  initial begin
    {grant, pw_act, pw_beat, pw_end, rty_seen, rty_done, berr, cmd_valid} = 8'h00;
    {cmd_write, cmd_vme, cmd_addr, cmd_be, cmd_wdata, cfg_addr} = '0;
    beat_bytes = 4'h8;
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 3; i++)
      rd(1'b0, msg[i], 32'h0);
    rd(1'b0, OFS_MASTER_CTL, 32'h80c00000);
    wr(1'b0, OFS_MASTER_CTL, 4'h6, 32'h00f03000, 1'b0);
    check({24'h0, arb_lvl, arb_sty, arb_rel, burst}, 32'h3f);
    $display("Test reset_values done");
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, msg[i], 4'hf, 32'h12345678 + i, 1'b0);
      wr(1'b1, msg[i], 4'h2, 32'haaaaaaaa, 1'b0);
      rd(1'b1, msg[i], 32'h1234aa78 + i);
    end
    wr(1'b0, 12'h500, 4'hf, 32'hffffffff, 1'b0);
    rd(1'b0, 12'h500, 32'h0);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 3; i++)
      rd(1'b1, msg[i], 32'h0);
    rd(1'b0, OFS_MASTER_CTL, 32'h80c00000);
    $display("Test message_words done");
    for (int i = 0; i < LOCK_COUNT; i++) begin
      a = (i < 4) ? OFS_LOCK_LOW : OFS_LOCK_HIGH;
      b = 4'h1 << (i % 4);
      for (int k = 0; k < 5; k++) begin
        wr(k[0], a, b, {4{lw[k]}}, 1'b0);
        cmd(1'b0, 1'b0, a, b, 32'h0);
        check({24'h0, q[8*(i%4) +: 8]}, {24'h0, lx[k]});
      end
      wr(1'b0, a, 4'h3, 32'h0, 1'b1);
    end
    $display("Test lock_flags done");
    wr(1'b0, OFS_MASTER_CTL, 4'h1, 32'h3c, 1'b0);
    for (int j = 0; j < 2; j++) begin
      cfg_addr = {8'h3c + j[7:0], 16'h1234};
      repeat (2) @(negedge clk);
      check({31'h0, cfg_type1}, {31'h0, j[0]});
    end
    $display("Test config_type done");
    grant = 1'b1;
    wr(1'b0, OFS_MASTER_CTL, 4'h4, 32'h00c80000, 1'b0);
    repeat (4) @(negedge clk);
    check({31'h0, bbsy}, 32'h1);
    wr(1'b0, msg[2], 4'hf, 32'h5a5a5a5a, 1'b0);
    rd(1'b1, msg[2], 32'h5a5a5a5a);
    rd(1'b0, OFS_MASTER_CTL, 32'h80cc003c);
    wr(1'b0, OFS_MASTER_CTL, 4'h8, 32'h8f000000, 1'b0);
    pw_act = 1'b1;
    pw_beat = 1'b1;
    pw_end = 1'b1;
    base = e_cnt;
    repeat (40) @(negedge clk);
    {pw_act, pw_beat, pw_end} = 3'b000;
    check(e_cnt - base, 0);
    check({31'h0, bbsy}, 32'h1);
    wr(1'b1, OFS_MASTER_CTL, 4'h4, 32'h00c80000, 1'b1);
    berr = 1'b1;
    repeat (12) @(negedge clk);
    berr = 1'b0;
    check({30'h0, hold_set, bbsy}, 32'h0);
    wr(1'b1, OFS_MASTER_CTL, 4'h4, 32'h00c00000, 1'b0);
    rd(1'b0, OFS_MASTER_CTL, 32'h8fc0003c);
    $display("Test bus_hold done");
    pw_run(4'h0, 16);
    pw_run(4'h1, 32);
    pw_run(RELEASE_MAX_SET, 512);
    pw_run(RELEASE_EVERY, 4);
    $display("Test early_release done");
    retry_run(RETRY_LIMIT_RST, 512);
    retry_run(4'h1, 64);
    retry_run(4'h0, 1024);
    $display("Test retry_limit done");
    summarize();
  end
endmodule : vme_ownership_mailbox_regs_tb
